// *** common/rtc_pkg.sv ***
package rtc_pkg;

  // -------------------------------------------------------------
  // word layout (lsb-first indices)
  // -------------------------------------------------------------
  localparam int unsigned WORD_W = 32;
  localparam int unsigned FRAC_W = 23;
  localparam int unsigned FRAC_LSB = 7;
  localparam int unsigned FRAC_MSB = 29;
  localparam int unsigned SEC_W = 32;

  // -------------------------------------------------------------
  // counting
  // -------------------------------------------------------------
  localparam int unsigned STEP_NS = 128;
  localparam int unsigned TERMINAL_NS = 999999872;
  localparam logic [22:0] FRAC_TERMINAL = 23'(TERMINAL_NS / STEP_NS);
  localparam logic [22:0] FRAC_RESET = 23'h000000;
  localparam logic [31:0] SEC_RESET = 32'h00000000;

  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int unsigned CORE_PERIOD_PS = 40000;
  localparam int unsigned MIN_CLOCK_RATIO = 2;
  // oscillator counted as stopped after this long without a step
  localparam int unsigned IDLE_NS = 1024;
  localparam int unsigned IDLE_CYCLES =
    (IDLE_NS * 1000) / CORE_PERIOD_PS;

  // -------------------------------------------------------------
  // register select and answer codes
  // -------------------------------------------------------------
  typedef enum logic
  {
    SEL_LOWER = 1'b0,
    SEL_UPPER = 1'b1
  } reg_sel_t;

  typedef enum logic [1:0]
  {
    RESP_IDLE = 2'b00,
    RESP_READ = 2'b01,
    RESP_WRITE = 2'b10,
    RESP_FAULT = 2'b11
  } resp_t;

endpackage : rtc_pkg

// *** logic/osc_toggle.sv ***
`timescale 1ns/1ps
module osc_toggle
(
  input wire logic osc_clk,
  input wire logic rst_b,
  input wire logic ce,
  output logic tick_toggle
);

  // -------------------------------------------------------------
  // reset and enable brought onto the oscillator clock
  // -------------------------------------------------------------
  logic rst_meta_b;
  logic rst_osc_b;
  logic ce_meta;
  logic ce_osc;

  always_ff @(posedge osc_clk)
  begin
    rst_meta_b <= rst_b;
    rst_osc_b <= rst_meta_b;
  end

  always_ff @(posedge osc_clk)
  begin
    ce_meta <= ce;
    ce_osc <= ce_meta;
  end

  // -------------------------------------------------------------
  // one flip per oscillator period
  // -------------------------------------------------------------
  // a toggle, not a pulse: a level survives any core phase
  always_ff @(posedge osc_clk)
  begin
    if (!rst_osc_b)
      tick_toggle <= 1'b0;
    else if (ce_osc)
      tick_toggle <= ~tick_toggle;
  end

endmodule : osc_toggle

// *** logic/seconds_nanoseconds_clock.sv ***
`timescale 1ns/1ps
module seconds_nanoseconds_clock
#(
  parameter int unsigned IDLE_LIMIT = rtc_pkg::IDLE_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic osc_clk,
  input wire logic spr_read,
  input wire logic spr_write,
  input wire logic spr_sel,
  input wire logic spr_supervisor,
  input wire logic [31:0] spr_wdata,
  output logic [31:0] spr_rdata,
  output logic spr_rvalid,
  output logic spr_wdone,
  output logic spr_fault,
  output logic second_pulse,
  output logic osc_idle,
  output logic rate_fault
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic [22:0] clock_fraction_lower;
  logic [31:0] clock_seconds_upper;
  logic [22:0] next_fraction;
  logic [31:0] next_seconds;
  logic tick_toggle;
  logic tick;
  logic tick_lost;
  logic at_terminal;
  logic wr_ok;
  logic wr_lower;
  logic wr_upper;
  logic carry;
  logic [15:0] idle_count;
  rtc_pkg::resp_t next_resp;

  // -------------------------------------------------------------
  // oscillator domain and crossing
  // -------------------------------------------------------------
  osc_toggle u_osc
  (
    .osc_clk(osc_clk),
    .rst_b(rst_b),
    .ce(ce),
    .tick_toggle(tick_toggle)
  );

  toggle_sync u_sync
  (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .async_in(tick_toggle),
    .event_pulse(tick),
    .lost_pulse(tick_lost)
  );

  // -------------------------------------------------------------
  // write qualification
  // -------------------------------------------------------------
  // user-level writes are refused and leave both counters alone
  // a read in the same cycle wins, so the write is dropped whole
  assign wr_ok = spr_write && spr_supervisor && !spr_read;
  assign wr_lower = wr_ok && (spr_sel == rtc_pkg::SEL_LOWER);
  assign wr_upper = wr_ok && (spr_sel == rtc_pkg::SEL_UPPER);

  // -------------------------------------------------------------
  // fraction counter
  // -------------------------------------------------------------
  assign at_terminal = (clock_fraction_lower == rtc_pkg::FRAC_TERMINAL);

  // a step that meets a lower-register write in the same cycle is dropped with its
  // carry, so the written value is exactly where counting resumes
  assign carry = tick && at_terminal && !wr_lower;

  always_comb
  begin
    next_fraction = clock_fraction_lower;
    if (wr_lower)
      // only the live bits are loaded
      next_fraction =
        spr_wdata[rtc_pkg::FRAC_MSB:rtc_pkg::FRAC_LSB];
    else if (tick)
    begin
      if (at_terminal)
        next_fraction = rtc_pkg::FRAC_RESET;
      else
        next_fraction = clock_fraction_lower + 23'h000001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      clock_fraction_lower <= rtc_pkg::FRAC_RESET;
    else if (ce)
      clock_fraction_lower <= next_fraction;
  end

  // -------------------------------------------------------------
  // seconds counter
  // -------------------------------------------------------------
  always_comb
  begin
    next_seconds = clock_seconds_upper;
    if (wr_upper)
      next_seconds = spr_wdata;
    else if (carry)
      // wraps from all ones to zero by plain overflow
      next_seconds = clock_seconds_upper + 32'h00000001;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      clock_seconds_upper <= rtc_pkg::SEC_RESET;
    else if (ce)
      clock_seconds_upper <= next_seconds;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      second_pulse <= 1'b0;
    else if (ce)
      second_pulse <= carry && !wr_upper;
  end

  // -------------------------------------------------------------
  // move-from and move-to answers
  // -------------------------------------------------------------
  // read wins a read/write collision in priority order below
  always_comb
  begin
    next_resp = rtc_pkg::RESP_IDLE;
    if (spr_read)
      next_resp = rtc_pkg::RESP_READ;
    else if (spr_write && spr_supervisor)
      next_resp = rtc_pkg::RESP_WRITE;
    else if (spr_write)
      next_resp = rtc_pkg::RESP_FAULT;
  end

  // reads only copy out; nothing here feeds the counters
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      spr_rdata <= 32'h00000000;
    else if (ce && next_resp == rtc_pkg::RESP_READ)
    begin
      if (spr_sel == rtc_pkg::SEL_UPPER)
        spr_rdata <= clock_seconds_upper;
      else
        spr_rdata <= {2'h0, clock_fraction_lower, 7'h00};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      spr_rvalid <= 1'b0;
      spr_wdone <= 1'b0;
      spr_fault <= 1'b0;
    end
    else if (ce)
    begin
      case (next_resp)
        rtc_pkg::RESP_READ:
        begin
          spr_rvalid <= 1'b1;
          spr_wdone <= 1'b0;
          spr_fault <= 1'b0;
        end
        rtc_pkg::RESP_WRITE:
        begin
          spr_rvalid <= 1'b0;
          spr_wdone <= 1'b1;
          spr_fault <= 1'b0;
        end
        rtc_pkg::RESP_FAULT:
        begin
          spr_rvalid <= 1'b0;
          spr_wdone <= 1'b0;
          spr_fault <= 1'b1;
        end
        default:
        begin
          spr_rvalid <= 1'b0;
          spr_wdone <= 1'b0;
          spr_fault <= 1'b0;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // oscillator health
  // -------------------------------------------------------------
  // a stopped or gated oscillator is legal; this only reports it
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      idle_count <= 16'h0000;
    else if (ce)
    begin
      if (tick)
        idle_count <= 16'h0000;
      else if (idle_count != IDLE_LIMIT[15:0])
        idle_count <= idle_count + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      osc_idle <= 1'b0;
    else if (ce)
      osc_idle <= (idle_count == IDLE_LIMIT[15:0]) && !tick;
  end

  // too slow a core clock loses steps; sticky until reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rate_fault <= 1'b0;
    else if (ce && tick_lost)
      rate_fault <= 1'b1;
  end

endmodule : seconds_nanoseconds_clock

// *** logic/toggle_sync.sv ***
`timescale 1ns/1ps
module toggle_sync
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic async_in,
  output logic event_pulse,
  output logic lost_pulse
);

  logic s1;
  logic s2;
  logic s3;
  logic accepted;
  logic primed;
  logic agree;
  logic [1:0] fill;

  // -------------------------------------------------------------
  // three stages, change taken once stages two and three agree
  // -------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else if (ce)
    begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign agree = (s2 == s3);

  // stages still holding reset zeros must not pass for the pin level
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      fill <= 2'h0;
    else if (ce && fill != 2'h3)
      fill <= fill + 2'h1;
  end

  // first agreed level after the stages filled only primes
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      accepted <= 1'b0;
      primed <= 1'b0;
      event_pulse <= 1'b0;
      lost_pulse <= 1'b0;
    end
    else if (ce)
    begin
      event_pulse <= 1'b0;
      lost_pulse <= 1'b0;
      if (!primed)
      begin
        if (fill == 2'h3 && agree)
        begin
          primed <= 1'b1;
          accepted <= s3;
        end
      end
      else if (agree)
      begin
        if (s3 != accepted)
        begin
          accepted <= s3;
          event_pulse <= 1'b1;
        end
      end
      else if (s3 != accepted && s2 == accepted)
        lost_pulse <= 1'b1;
    end
  end

endmodule : toggle_sync

// *** verification/osc_model.sv ***
`timescale 1ns/1ps
module osc_model
(
  input wire logic en,
  output logic osc_clk
);
  // ------------------------------------------------
  // gated oscillator, stands low while gated off
  // ------------------------------------------------
  initial osc_clk = 1'h0;
  always
  begin
    wait (en);
    #7;
    while (en)
    begin
      osc_clk = 1'h1;
      #15;
      osc_clk = 1'h0;
      #15;
    end
  end
endmodule : osc_model

// *** verification/seconds_nanoseconds_clock_props.sv ***
`timescale 1ns/1ps
module seconds_nanoseconds_clock_props
#(
  parameter int unsigned IDLE_LIMIT = 4
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic osc_clk,
  input wire logic spr_read,
  input wire logic spr_write,
  input wire logic spr_sel,
  input wire logic spr_supervisor,
  input wire logic [31:0] spr_wdata,
  input wire logic [31:0] spr_rdata,
  input wire logic spr_rvalid,
  input wire logic spr_wdone,
  input wire logic spr_fault,
  input wire logic second_pulse,
  input wire logic osc_idle,
  input wire logic rate_fault
);
  // ------------------------------------------------
  // register access, seconds carry and rate fault
  // ------------------------------------------------
  logic [22:0] wfrac;
  assign wfrac = spr_wdata[29:7];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_rd;
    ce && spr_read;
  endsequence
  sequence s_sup_wr;
    ce && spr_write && !spr_read && spr_supervisor;
  endsequence
  sequence s_user_wr;
    ce && spr_write && !spr_read && !spr_supervisor;
  endsequence
  a_read_answer: assert property (s_rd |=> spr_rvalid && !spr_wdone)
    else $error("read not answered");
  a_write_taken: assert property (s_sup_wr |=> spr_wdone && !spr_fault)
    else $error("write not taken");
  a_user_refused: assert property (s_user_wr |=> spr_fault && !spr_wdone)
    else $error("user write not refused");
  a_no_stray: assert property (!(ce && (spr_read || spr_write))
    |=> !spr_rvalid && !spr_wdone && !spr_fault) else $error("stray answer");
  a_frac_zeros: assert property (spr_rvalid && !$past(spr_sel)
    |-> spr_rdata[6:0] == 7'h00 && spr_rdata[31:30] == 2'h0)
    else $error("unused fraction bits set");
  a_rdata_holds: assert property (!spr_rvalid && $past(rst_b)
    |-> $stable(spr_rdata)) else $error("read data moved");
  a_frac_load: assert property ((s_sup_wr and !spr_sel) ##2
    (s_rd and !spr_sel) |=> spr_rdata[29:7] == $past(wfrac, 3)
    || spr_rdata[29:7] == $past(wfrac, 3) + 23'h1)
    else $error("fraction load wrong");
  a_sec_load: assert property ((s_sup_wr and spr_sel) ##2
    (s_rd and spr_sel) |=> spr_rdata == $past(spr_wdata, 3)
    || spr_rdata == $past(spr_wdata, 3) + 32'h1)
    else $error("seconds load wrong");
  a_second_single: assert property (second_pulse |=> !second_pulse)
    else $error("double carry");
  a_fault_sticky: assert property (rate_fault |=> rate_fault)
    else $error("rate fault cleared");
endmodule : seconds_nanoseconds_clock_props

bind seconds_nanoseconds_clock seconds_nanoseconds_clock_props
  #(.IDLE_LIMIT(IDLE_LIMIT)) props_inst (.clk(clk), .rst_b(rst_b),
  .ce(ce), .osc_clk(osc_clk), .spr_read(spr_read),
  .spr_write(spr_write), .spr_sel(spr_sel),
  .spr_supervisor(spr_supervisor), .spr_wdata(spr_wdata),
  .spr_rdata(spr_rdata), .spr_rvalid(spr_rvalid), .spr_wdone(spr_wdone),
  .spr_fault(spr_fault), .second_pulse(second_pulse),
  .osc_idle(osc_idle), .rate_fault(rate_fault));

// *** verification/test_seconds_nanoseconds_clock.sv ***
`timescale 1ns/1ps
module test_seconds_nanoseconds_clock;
  // ------------------------------------------------
  // bench
  // ------------------------------------------------
  localparam logic [22:0] TERM = rtc_pkg::FRAC_TERMINAL;
  logic clk = 1'h0, rst_b = 1'h0, ce = 1'h1, osc_en = 1'h1, osc_clk;
  logic spr_read = 1'h0, spr_write = 1'h0, spr_sel = 1'h0;
  logic spr_supervisor = 1'h0, spr_rvalid, spr_wdone, spr_fault;
  logic second_pulse, osc_idle, rate_fault;
  logic [31:0] spr_wdata = 32'h0, spr_rdata, sec, lo, q;
  logic [22:0] f;
  int fails = 0, samples_checked = 0, pulses = 0, exp_pulses = 0;
  initial forever #20 clk = ~clk;
  seconds_nanoseconds_clock #(.IDLE_LIMIT(4)) seconds_nanoseconds_clock_inst
    (.clk(clk), .rst_b(rst_b), .ce(ce), .osc_clk(osc_clk),
    .spr_read(spr_read), .spr_write(spr_write), .spr_sel(spr_sel),
    .spr_supervisor(spr_supervisor), .spr_wdata(spr_wdata),
    .spr_rdata(spr_rdata), .spr_rvalid(spr_rvalid), .spr_wdone(spr_wdone),
    .spr_fault(spr_fault), .second_pulse(second_pulse),
    .osc_idle(osc_idle), .rate_fault(rate_fault));
  osc_model osc_model_inst (.en(osc_en), .osc_clk(osc_clk));
  always @(posedge clk) if (second_pulse === 1'h1) pulses <= pulses + 1;
  function automatic logic [31:0] frac_word(input logic [22:0] v);
    return {2'h0, v, 7'h00};
  endfunction : frac_word
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task acc(input logic w, input logic s, input logic sup,
    input logic [31:0] d);
    @(posedge clk);
    spr_read <= ~w;
    spr_write <= w;
    spr_sel <= s;
    spr_supervisor <= sup;
    spr_wdata <= d;
    @(posedge clk);
    spr_read <= 1'h0;
    spr_write <= 1'h0;
    #1;
    chk({31'h0, w ? (sup ? spr_wdone : spr_fault) : spr_rvalid}, 32'h1);
  endtask : acc
  // one oscillator edge, then let the synchroniser settle
  task pulse;
    osc_en <= 1'h1;
    @(posedge osc_clk);
    osc_en <= 1'h0;
    repeat (12) @(posedge clk);
    #1;
  endtask : pulse
  task end_sim;
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  initial
  begin
    #300000;
    fails++;
    end_sim();
  end
  initial
  begin
    void'($urandom(32'h7BC78AB7));
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    // two more edges release the oscillator side's reset, then gate it
    repeat (2) @(posedge osc_clk);
    osc_en <= 1'h0;
    repeat (6) @(posedge clk);
    chk(spr_rdata, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      f = (i < 2) ? TERM : 23'($urandom_range(7812498));
      sec = (i == 0) ? 32'hFFFFFFFF : $urandom;
      acc(1'h1, 1'h0, 1'h1, {2'($urandom), f, 7'($urandom)});
      acc(1'h0, 1'h0, 1'h0, 32'h0);
      chk(spr_rdata, frac_word(f));
      acc(1'h1, 1'h1, 1'h1, sec);
      acc(1'h0, 1'h1, 1'h0, 32'h0);
      acc(1'h0, 1'h1, 1'h0, 32'h0);
      chk(spr_rdata, sec);
      pulse();
      chk({31'h0, osc_idle}, 32'h1);
      if (f == TERM) exp_pulses++;
      acc(1'h0, 1'h0, 1'h0, 32'h0);
      chk(spr_rdata, frac_word(f == TERM ? 23'h0 : f + 23'h1));
      sec = (f == TERM) ? sec + 32'h1 : sec;
      acc(1'h1, 1'h1, 1'h0, ~sec);
      acc(1'h0, 1'h1, 1'h0, 32'h0);
      chk(spr_rdata, sec);
    end
    chk(32'(pulses), 32'(exp_pulses));
    chk({31'h0, rate_fault}, 32'h0);
    // counts on its own from a value just short of a second
    acc(1'h1, 1'h0, 1'h1, frac_word(TERM - 23'h1));
    acc(1'h1, 1'h1, 1'h1, 32'h0000FFFF);
    repeat (2) pulse();
    for (int k = 0; k < 8; k++)
    begin
      acc(1'h0, 1'h1, 1'h0, 32'h0);
      sec = spr_rdata;
      acc(1'h0, 1'h0, 1'h0, 32'h0);
      lo = spr_rdata;
      acc(1'h0, 1'h1, 1'h0, 32'h0);
      if (spr_rdata === sec) break;
    end
    chk(sec, 32'h00010000);
    chk(lo, 32'h0);
    // frozen by the enable: a write is neither answered nor taken
    @(posedge clk);
    ce <= 1'h0;
    spr_write <= 1'h1;
    spr_sel <= 1'h1;
    spr_supervisor <= 1'h1;
    @(posedge clk);
    spr_write <= 1'h0;
    #1;
    chk({31'h0, spr_wdone}, 32'h0);
    @(posedge clk);
    ce <= 1'h1;
    acc(1'h0, 1'h1, 1'h0, 32'h0);
    chk(spr_rdata, 32'h00010000);
    // a core slower than twice the free-running oscillator loses steps
    osc_en <= 1'h1;
    repeat (50) @(posedge clk);
    chk({31'h0, rate_fault}, 32'h1);
    end_sim();
  end
endmodule : test_seconds_nanoseconds_clock
